/* File: rtl/cscu_regs.svh */
// register offsets, field positions, reset values and timing for the clock command unit
`ifndef CSCU_REGS_SVH
`define CSCU_REGS_SVH

// register indices; each register takes one word, byte address = 4 * index
`define CSCU_IDX_CMD        8'h62
`define CSCU_IDX_SEL        8'h63
`define CSCU_IDX_IRQ_STAT   8'h64
`define CSCU_IDX_IRQ_MASK   8'h65
`define CSCU_ADDR_CMD       12'h188
`define CSCU_ADDR_SEL       12'h18C
`define CSCU_ADDR_IRQ_STAT  12'h190
`define CSCU_ADDR_IRQ_MASK  12'h194

// command register fields
`define CSCU_CMD_CCE_BIT    7
`define CSCU_CMD_RDY_BIT    4
`define CSCU_CMD_CODE_MSB   3
`define CSCU_CMD_OTHER_MASK 8'h7F

// selection register fields
`define CSCU_SEL_OUT_BIT    6
`define CSCU_SEL_SUT_MSB    5
`define CSCU_SEL_SUT_LSB    4
`define CSCU_SEL_SRC_MSB    3

// interrupt status bits
`define CSCU_IRQ_READY_BIT  0
`define CSCU_IRQ_DROP_BIT   1
`define CSCU_IRQ_WIDTH      2

// reset values and window length
`define CSCU_CMD_RESET      8'h00
`define CSCU_WINDOW_CYCLES  3'h4

`endif

/* File: rtl/cscu_pkg.sv */
// types shared by the clock command unit
`default_nettype none

package cscu_pkg;

    // decoded clock commands
    typedef enum logic [3:0] {
        CSCU_CMD_NONE    = 4'h0,
        CSCU_CMD_DISABLE = 4'h1,
        CSCU_CMD_ENABLE  = 4'h2,
        CSCU_CMD_REQUEST = 4'h3,
        CSCU_CMD_SWITCH  = 4'h4,
        CSCU_CMD_RECOVER = 4'h5,
        CSCU_CMD_WDT_ARL = 4'h6,
        CSCU_CMD_OUTPUT_FUSE   = 4'h7
    } cscu_cmd_t;

endpackage : cscu_pkg

`default_nettype wire

/* File: rtl/cscu_window.sv */
// timed change-enable window of the command register
`timescale 1ns/10ps
`default_nettype none
`include "cscu_regs.svh"

module cscu_window
    import cscu_pkg::*;
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // requests from the register write path
    input  wire logic open_req,
    input  wire logic close_req,
    // window state
    output logic      open_r
);

    logic [2:0] count_r;   // cycles since the window opened

    // window opens on an accepted arming write, closes on timeout or command write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            open_r  <= 1'b0;
            count_r <= 3'h0;
        end
        else if (open_r)
        begin
            // rewriting the enable bit neither restarts nor clears it
            if (close_req || count_r == `CSCU_WINDOW_CYCLES - 3'h1)
            begin
                open_r  <= 1'b0;
                count_r <= 3'h0;
            end
            else
            begin
                count_r <= count_r + 3'h1;
            end
        end
        else if (open_req)
        begin
            open_r  <= 1'b1;
            count_r <= 3'h0;
        end
    end

endmodule : cscu_window

`default_nettype wire

/* File: rtl/cscu_top.sv */
// clock switch command unit: apb registers, protected command issue, source tracking
`timescale 1ns/10ps
`default_nettype none
`include "cscu_regs.svh"

module cscu_top
    import cscu_pkg::*;
(
    // apb clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // fuse straps
    input  wire logic        output_fuse,
    input  wire logic [1:0]  startup_fuse,
    input  wire logic [3:0]  source_fuse,
    // clock availability logic and clock switch
    input  wire logic        avail_stable,
    input  wire logic [3:0]  system_source,
    // command strobes to the clock switch
    output logic             cmd_valid,
    output logic [3:0]       cmd_code,
    output logic [3:0]       cmd_source,
    output logic [1:0]       cmd_startup,
    output logic             cmd_output_sel,
    output logic             wdt_auto_reload,
    // interrupt
    output logic             irq
);

    // register state
    logic [3:0]  command_code_r;      // last command code accepted
    logic        source_ready_flag_r; // ready flag
    logic        output_select_bit_r; // clock output setting
    logic [1:0]  startup_time_code_r; // start-up time code
    logic [3:0]  source_select_code_r;// selected source code
    logic [`CSCU_IRQ_WIDTH-1:0] irq_stat_r; // sticky events
    logic [`CSCU_IRQ_WIDTH-1:0] irq_mask_r; // event enables
    logic        straps_loaded_r;     // fuses captured after reset
    logic        wdt_arl_r;           // watchdog auto reload mode

    // synchronised inputs
    logic        stable_s1_r;
    logic        stable_s2_r;
    logic [3:0]  sysrc_s1_r;
    logic [3:0]  sysrc_s2_r;
    logic        stable_prev_r;       // for edge detection on stable level
    logic        stable_rise;         // synchronised availability went high
    logic        stable_fall;         // synchronised availability went low
    logic [`CSCU_IRQ_WIDTH-1:0] stat_clr; // write-one-to-clear pattern

    // apb decode
    logic        wr_access;
    logic        rd_access;
    logic        hit_cmd;
    logic        hit_sel;
    logic        hit_stat;
    logic        hit_mask;
    logic        hit_any;
    logic [7:0]  wbyte;
    logic        window_open;
    logic        arm_write;
    logic        code_write;
    logic        cmd_accept;
    logic [3:0]  new_code;

    // pack the command register for reads
    function automatic logic [7:0] cmd_read(input logic cce, input logic rdy,
                                            input logic [3:0] code);
        logic [7:0] v;
        v = 8'h00;
        v[`CSCU_CMD_CCE_BIT] = cce;
        v[`CSCU_CMD_RDY_BIT] = rdy;
        v[`CSCU_CMD_CODE_MSB:0] = code;
        return v;
    endfunction : cmd_read

    // apb access decode: every access completes in its first access cycle
    assign wr_access = psel && penable && pwrite;
    assign rd_access = psel && !penable && !pwrite;
    assign hit_cmd   = paddr == `CSCU_ADDR_CMD;
    assign hit_sel   = paddr == `CSCU_ADDR_SEL;
    assign hit_stat  = paddr == `CSCU_ADDR_IRQ_STAT;
    assign hit_mask  = paddr == `CSCU_ADDR_IRQ_MASK;
    assign hit_any   = hit_cmd || hit_sel || hit_stat || hit_mask;
    assign wbyte     = pstrb[0] ? pwdata[7:0] : 8'h00;

    // arming write: enable bit one, every other bit zero
    assign arm_write  = wr_access && hit_cmd && pstrb[0] &&
                        pwdata[`CSCU_CMD_CCE_BIT] &&
                        ((pwdata[7:0] & `CSCU_CMD_OTHER_MASK) == 8'h00);
    // command write: enable bit zero while the window stands open
    assign code_write = wr_access && hit_cmd && pstrb[0] &&
                        !pwdata[`CSCU_CMD_CCE_BIT];
    assign cmd_accept = code_write && window_open;
    assign new_code   = pwdata[`CSCU_CMD_CODE_MSB:0];

    // the availability rise feeds both the ready flag and the event bits, the fall only the event bits
    assign stable_rise = stable_s2_r && !stable_prev_r;
    assign stable_fall = !stable_s2_r && stable_prev_r;
    assign stat_clr    = (wr_access && hit_stat) ? wbyte[`CSCU_IRQ_WIDTH-1:0]
                                                 : {`CSCU_IRQ_WIDTH{1'b0}};

    // change-enable window
    cscu_window u_window (
        .pclk      (pclk),
        .presetn   (presetn),
        .open_req  (arm_write),
        .close_req (code_write),
        .open_r    (window_open)
    );

    // two-flop synchronisers for availability and system source
    // system source code must be held steady while sampled: its bits are not skew-safe
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stable_s1_r   <= 1'b0;
            stable_s2_r   <= 1'b0;
            sysrc_s1_r    <= 4'h0;
            sysrc_s2_r    <= 4'h0;
            stable_prev_r <= 1'b0;
        end
        else
        begin
            stable_s1_r   <= avail_stable;
            stable_s2_r   <= stable_s1_r;
            sysrc_s1_r    <= system_source;
            sysrc_s2_r    <= sysrc_s1_r;
            stable_prev_r <= stable_s2_r;
        end
    end

    // command code field: only an accepted write stores it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            command_code_r <= 4'(`CSCU_CMD_RESET);
        end
        else if (cmd_accept)
        begin
            command_code_r <= new_code;
        end
    end

    // ready flag: cleared by request or enable, set when availability logic reports stable
    // a rise in the same cycle as the clear wins, so a stable source is never missed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            source_ready_flag_r <= 1'b0;
        end
        else if (stable_rise)
        begin
            source_ready_flag_r <= 1'b1;
        end
        else if (cmd_accept && (new_code == CSCU_CMD_REQUEST ||
                                new_code == CSCU_CMD_ENABLE))
        begin
            source_ready_flag_r <= 1'b0;
        end
    end

    // selection register: fuse preset after reset release, software writes, recover
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            output_select_bit_r  <= 1'b0;
            startup_time_code_r  <= 2'h0;
            source_select_code_r <= 4'h0;
            straps_loaded_r      <= 1'b0;
        end
        else if (!straps_loaded_r)
        begin
            // capture the fuse straps on the first edge after release
            output_select_bit_r  <= ~output_fuse;
            startup_time_code_r  <= startup_fuse;
            source_select_code_r <= source_fuse;
            straps_loaded_r      <= 1'b1;
        end
        else if (cmd_accept && new_code == CSCU_CMD_RECOVER)
        begin
            // only the source field is recovered
            source_select_code_r <= sysrc_s2_r;
        end
        else if (wr_access && hit_sel && pstrb[0])
        begin
            output_select_bit_r  <= pwdata[`CSCU_SEL_OUT_BIT];
            startup_time_code_r  <= pwdata[`CSCU_SEL_SUT_MSB:`CSCU_SEL_SUT_LSB];
            source_select_code_r <= pwdata[`CSCU_SEL_SRC_MSB:0];
        end
    end

    // command strobe toward the clock switch, one cycle per accepted command of code 1 to 7
    // settings are taken as they stood before the accepting write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_valid      <= 1'b0;
            cmd_code       <= 4'h0;
            cmd_source     <= 4'h0;
            cmd_startup    <= 2'h0;
            cmd_output_sel <= 1'b0;
        end
        else
        begin
            // codes with the top bit set and code zero issue nothing
            cmd_valid <= cmd_accept && !new_code[3] && new_code != CSCU_CMD_NONE;
            if (cmd_accept)
            begin
                cmd_code       <= new_code;
                cmd_source     <= source_select_code_r;
                cmd_startup    <= startup_time_code_r;
                cmd_output_sel <= output_select_bit_r;
            end
        end
    end

    // watchdog automatic reload mode, held once commanded
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wdt_arl_r       <= 1'b0;
            wdt_auto_reload <= 1'b0;
        end
        else
        begin
            if (cmd_accept && new_code == CSCU_CMD_WDT_ARL)
            begin
                wdt_arl_r <= 1'b1;
            end
            wdt_auto_reload <= wdt_arl_r || (cmd_accept && new_code == CSCU_CMD_WDT_ARL);
        end
    end

    // interrupt status: availability rise and availability loss; set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_stat_r <= '0;
        end
        else
        begin
            // bit 1 availability lost, bit 0 availability rose
            irq_stat_r <= (irq_stat_r & ~stat_clr) | {stable_fall, stable_rise};
        end
    end

    // interrupt mask
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_mask_r <= '0;
        end
        else if (wr_access && hit_mask && pstrb[0])
        begin
            irq_mask_r <= pwdata[`CSCU_IRQ_WIDTH-1:0];
        end
    end

    // interrupt output
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    // apb answer: read data captured in setup, ready in the access cycle
    // reads have no side effects on any register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit_any;
            if (rd_access)
            begin
                if (hit_cmd)
                    prdata <= {24'h00_0000, cmd_read(window_open, source_ready_flag_r,
                                                      command_code_r)};
                else if (hit_sel)
                    prdata <= {24'h00_0000, 1'b0, output_select_bit_r,
                               startup_time_code_r, source_select_code_r};
                else if (hit_stat)
                    prdata <= {30'h0000_0000, irq_stat_r};
                else if (hit_mask)
                    prdata <= {30'h0000_0000, irq_mask_r};
                else
                    prdata <= 32'h0000_0000;
            end
        end
    end

endmodule : cscu_top

`default_nettype wire

/* File: dv/cscu_top_asserts.sv */
// port assertions for the clock command unit
`timescale 1ns/10ps
`default_nettype none
`include "cscu_regs.svh"

module cscu_top_asserts
(
    // clock, reset and apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // command strobes and interrupt
    input wire logic        cmd_valid,
    input wire logic [3:0]  cmd_code,
    input wire logic        wdt_auto_reload,
    input wire logic        irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic       wr_cmd;  // completed write to the command register
    logic       acc;     // command write taken inside the window
    logic [2:0] win_r;   // edges left in the change window
    logic       rd_cmd;  // read of the command register answered
    assign wr_cmd = psel && penable && pwrite && pready && (paddr == `CSCU_ADDR_CMD);
    assign acc    = wr_cmd && !pwdata[7] && (win_r != 3'h0);
    assign rd_cmd = pready && !pwrite && (paddr == `CSCU_ADDR_CMD);

    // window tracker: opens on a clean arm, closes on a command or on time-out
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            win_r <= 3'h0;
        else if (wr_cmd && pwdata[7:0] == 8'h80 && win_r == 3'h0)
            win_r <= `CSCU_WINDOW_CYCLES;
        else if (acc)
            win_r <= 3'h0;
        else if (win_r != 3'h0)
            win_r <= win_r - 3'h1;
    end

    a_pready_pulse:
    assert property (psel && !penable |=> pready ##1 !pready) else $error("bad pready");
    a_cmd_issue:
    assert property (acc && pwdata[3:0] inside {[4'h1:4'h7]} |=>
        cmd_valid && cmd_code == $past(pwdata[3:0])) else $error("command lost");
    a_code_none:
    assert property (acc && (pwdata[3] || pwdata[3:0] == 4'h0) |=> !cmd_valid)
        else $error("no-command code issued");
    a_cmd_cause:
    assert property (cmd_valid |-> $past(acc)) else $error("command outside window");
    a_cmd_single:
    assert property (cmd_valid |=> !cmd_valid) else $error("command repeated");
    a_wdt_set:
    assert property (acc && pwdata[3:0] == 4'h6 |=> wdt_auto_reload) else $error("no reload");
    a_wdt_keep:
    assert property (wdt_auto_reload |=> wdt_auto_reload) else $error("reload dropped");
    a_win_read:
    assert property (rd_cmd |-> prdata[7] == ($past(win_r) != 3'h0)) else $error("window bit");
    a_rsvd_cmd:
    assert property (rd_cmd |-> prdata[6:5] == 2'h0 && prdata[31:8] == 24'h0)
        else $error("command reserved bits");
    a_rsvd_sel:
    assert property (pready && !pwrite && paddr == `CSCU_ADDR_SEL |-> prdata[31:7] == 25'h0)
        else $error("selection reserved bits");
    a_err_unmapped:
    assert property (pready && pslverr |-> !(paddr inside {`CSCU_ADDR_CMD, `CSCU_ADDR_SEL,
        `CSCU_ADDR_IRQ_STAT, `CSCU_ADDR_IRQ_MASK})) else $error("error on mapped address");
    a_irq_clear:
    assert property ($fell(irq) |-> $past(psel && penable && pwrite, 2)) else $error("irq fell");

    // main scenarios reached
    c_recover: cover property (acc && pwdata[3:0] == 4'h5);
    c_unmapped: cover property (pready && pslverr);
    c_irq: cover property ($rose(irq));
endmodule : cscu_top_asserts

bind cscu_top cscu_top_asserts chk_u
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .wdt_auto_reload(wdt_auto_reload), .irq(irq)
);

`default_nettype wire

/* File: dv/cscu_top_tb_top.sv */
// self-checking bench for the clock command unit
`timescale 1ns/10ps
`default_nettype none
`include "cscu_regs.svh"

module cscu_top_tb_top;
    // apb master and availability inputs
    logic        pclk          = 1'h0;
    logic        presetn       = 1'h0;
    logic        psel          = 1'h0;
    logic        penable       = 1'h0;
    logic        pwrite        = 1'h0;
    logic [11:0] paddr         = 12'h000;
    logic [31:0] pwdata        = 32'h0;
    logic [3:0]  pstrb         = 4'hF;
    logic        avail_stable  = 1'h0;
    logic [3:0]  system_source = 4'h9;
    logic        output_fuse   = 1'h0;
    logic [1:0]  startup_fuse  = 2'h2;
    logic [3:0]  source_fuse   = 4'h5;
    // design outputs
    logic [31:0] prdata;
    logic        pready, pslverr, cmd_valid, cmd_output_sel, wdt_auto_reload, irq;
    logic [3:0]  cmd_code, cmd_source;
    logic [1:0]  cmd_startup;
    // bench state
    int          num_errors    = 0;
    int          total_checks  = 0;
    int          ncmd          = 0;
    int          n0;
    logic [31:0] rd;
    logic        err;

    cscu_top dut_u
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .output_fuse(output_fuse), .startup_fuse(startup_fuse),
        .source_fuse(source_fuse),
        .avail_stable(avail_stable), .system_source(system_source), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_source(cmd_source), .cmd_startup(cmd_startup),
        .cmd_output_sel(cmd_output_sel), .wdt_auto_reload(wdt_auto_reload), .irq(irq)
    );

    // 10 MHz clock
    initial
    begin
        forever #50 pclk = ~pclk;
    end

    // counts command strobes
    always @(posedge pclk)
    begin
        if (cmd_valid === 1'h1)
            ncmd <= ncmd + 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask : chk

    // one apb transfer, request held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
    begin
        n = 0;
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'h1);
        chk(32'(n), 32'h1);
        rd  = prdata;
        err = pslverr;
    end
    endtask : xfer

    // release the bus for k cycles
    task automatic gap(input int k);
    begin
        psel    <= 1'h0;
        penable <= 1'h0;
        repeat (k) @(posedge pclk);
    end
    endtask : gap

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
    begin
        xfer(1'h1, a, d);
        gap(1);
    end
    endtask : wr

    task automatic rdv(input logic [11:0] a);
    begin
        xfer(1'h0, a, 8'h00);
        gap(1);
    end
    endtask : rdv

    // na arms of value av, g idle cycles, nc writes of code c, e strobes expected
    task automatic issue(input logic [7:0] av, input int na, input int g,
                         input logic [3:0] c, input int nc, input int e);
    begin
        n0 = ncmd;
        repeat (na) xfer(1'h1, `CSCU_ADDR_CMD, av);
        if (g > 0)
            gap(g);
        repeat (nc) xfer(1'h1, `CSCU_ADDR_CMD, {4'h0, c});
        gap(3);
        chk(32'(ncmd - n0), 32'(e));
    end
    endtask : issue

    task automatic final_report;
    begin
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask : final_report

    // hang guard
    initial
    begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        final_report;
    end

    // main sequence
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        repeat (2) @(posedge pclk);
        rdv(`CSCU_ADDR_CMD);
        chk(rd, 32'h0);
        rdv(`CSCU_ADDR_SEL);
        chk(rd, 32'h65);
        wr(`CSCU_ADDR_SEL, 8'hFF);
        rdv(`CSCU_ADDR_SEL);
        chk(rd, 32'h7F);
        wr(`CSCU_ADDR_SEL, 8'h5C);
        // codes 0 to 8, window gaps of 0, 1 and 2 idle cycles
        for (int c = 0; c < 9; c++)
        begin
            issue(8'h80, 1, c % 3, 4'(c), 1, 32'(c > 0 && c < 8));
            if (c > 0 && c < 8)
                chk(32'(cmd_code), 32'(c));
            if (c == 1 || c == 2)
                chk(32'(cmd_startup), 32'h1);
            if (c > 0 && c < 5)
                chk(32'(cmd_source), 32'hC);
            if (c == 7)
                chk(32'(cmd_output_sel), 32'h1);
        end
        rdv(`CSCU_ADDR_SEL);
        chk(rd, 32'h59);
        chk(32'(wdt_auto_reload), 32'h1);
        // refused and boundary sequences
        issue(8'h81, 1, 1, 4'h1, 1, 0);
        issue(8'h80, 0, 0, 4'h1, 1, 0);
        rdv(`CSCU_ADDR_CMD);
        chk(rd, 32'h08);
        issue(8'h80, 1, 3, 4'h1, 1, 0);
        issue(8'h80, 1, 0, 4'h1, 2, 1);
        issue(8'h80, 2, 1, 4'h1, 1, 0);
        issue(8'h80, 2, 0, 4'h1, 1, 1);
        // ready flag and interrupt, cleared by request then by enable
        wr(`CSCU_ADDR_IRQ_MASK, 8'h01);
        for (int k = 3; k > 1; k--)
        begin
            avail_stable <= 1'h1;
            gap(6);
            rdv(`CSCU_ADDR_CMD);
            chk(rd & 32'h10, 32'h10);
            chk(32'(irq), 32'h1);
            issue(8'h80, 1, 1, 4'(k), 1, 1);
            rdv(`CSCU_ADDR_CMD);
            chk(rd, 32'(k));
            wr(`CSCU_ADDR_IRQ_STAT, 8'h01);
            gap(1);
            chk(32'(irq), 32'h0);
            avail_stable <= 1'h0;
            gap(6);
            chk(32'(irq), 32'h0);
            rdv(`CSCU_ADDR_IRQ_STAT);
            chk(rd, 32'h2);
            wr(`CSCU_ADDR_IRQ_STAT, 8'h02);
        end
        // unmapped address
        rdv(12'h1A0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        // reset in mid-run
        presetn      <= 1'h0;
        output_fuse  <= 1'h1;
        startup_fuse <= 2'h1;
        source_fuse  <= 4'hA;
        gap(2);
        chk(32'(wdt_auto_reload), 32'h0);
        presetn <= 1'h1;
        gap(2);
        rdv(`CSCU_ADDR_SEL);
        chk(rd, 32'h1A);
        final_report;
    end
endmodule : cscu_top_tb_top

`default_nettype wire
